// >>> ccotmr_top.sv
// capture/compare timer with one-shot down-counters and interval events
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ccotmr_top #(
    parameter int PULSE_DOWN_COUNTER_W = ccotmr_pkg::PULSE_DOWN_COUNTER_W_DEF
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [ccotmr_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // timer pins
    input wire logic [ccotmr_pkg::NUM_CAP0-1:0] ch0CaptureIn,
    input wire logic [ccotmr_pkg::NUM_GR-1:0] gpPinIn,
    output logic [ccotmr_pkg::NUM_GR-1:0] gpPinOut,
    output logic [ccotmr_pkg::NUM_GR-1:0] gpPinOe,
    output logic [ccotmr_pkg::NUM_DOWN-1:0] pulseOut,
    output logic adcStart,
    // interrupt requests
    output logic [ccotmr_pkg::NUM_CH-1:0] ovfIrq,
    output logic [ccotmr_pkg::NUM_CAP0-1:0] cap0Irq,
    output logic [ccotmr_pkg::NUM_GR-1:0] grIrq,
    output logic [ccotmr_pkg::NUM_DOWN-1:0] downIrq,
    output logic intervalIrq
);
    import ccotmr_pkg::*;

    if (PULSE_DOWN_COUNTER_W < 2 || PULSE_DOWN_COUNTER_W > 32) begin : g_bad_width
        $error("PULSE_DOWN_COUNTER_W must lie in 2..32");
    end

    // registers
    logic [NUM_CH-1:0] runReg;
    logic [7:0] intervalEnReg;
    logic [NUM_DOWN-1:0] linkReg;
    logic [NUM_DOWN-1:0] startBitReg;
    logic [NUM_DOWN-1:0] startBitNext;
    logic [IE_CNT_W-1:0] ieCntReg;
    logic [NUM_GR-1:0] ieGrReg;
    logic [NUM_DOWN-1:0] ieDownReg;
    logic [ST_CNT_W-1:0] stCntReg;
    logic [NUM_GR-1:0] stGrReg;
    logic [NUM_DOWN-1:0] stDownReg;
    logic [7:0] clkSelReg;
    logic [7:0] cap0EdgeReg;
    logic [31:0] cntReg [NUM_CH];
    logic [31:0] cap0Reg [NUM_CAP0];
    logic [PULSE_DOWN_COUNTER_W-1:0] dcntReg [NUM_DOWN];
    logic [15:0] grReg [NUM_GR];
    ccotmr_pinctl_type pctlReg [NUM_GR];
    logic [PRESC_W-1:0] prescReg;
    logic [NUM_GR-1:0] gpPrevReg;
    logic [NUM_CAP0-1:0] cap0PrevReg;
    logic [NUM_IV-1:0] ivPrevReg;
    logic [NUM_DOWN-1:0] linkPendReg;
    logic [NUM_DOWN-1:0] zeroDlyReg;

    // bus decode
    logic accept;
    logic wrEn;
    logic [ADDR_W-1:0] relCnt, relCap0, relDcnt, relGr, relPctl;
    logic [IDX_W-1:0] idxCnt, idxCap0, idxDcnt, idxGr, idxPctl;
    logic hitCnt, hitCap0, hitDcnt, hitGr, hitPctl;
    assign accept = ce & (read | write) & ~waitrequest;
    assign wrEn = accept & write;
    assign relCnt = address - OFS_CNT_BASE;
    assign relCap0 = address - OFS_CAP0_BASE;
    assign relDcnt = address - OFS_PULSE_DOWN_COUNTER_BASE;
    assign relGr = address - OFS_GR_BASE;
    assign relPctl = address - OFS_PCTL_BASE;
    assign idxCnt = relCnt[IDX_W+1:2];
    assign idxCap0 = relCap0[IDX_W+1:2];
    assign idxDcnt = relDcnt[IDX_W+1:2];
    assign idxGr = relGr[IDX_W+1:2];
    assign idxPctl = relPctl[IDX_W+1:2];
    assign hitCnt = address >= OFS_CNT_BASE && idxCnt < IDX_W'(NUM_CH)
        && relCnt[ADDR_W-1:IDX_W+2] == '0;
    assign hitCap0 = address >= OFS_CAP0_BASE
        && idxCap0 < IDX_W'(NUM_CAP0) && relCap0[ADDR_W-1:IDX_W+2] == '0;
    assign hitDcnt = address >= OFS_PULSE_DOWN_COUNTER_BASE
        && idxDcnt < IDX_W'(NUM_DOWN) && relDcnt[ADDR_W-1:IDX_W+2] == '0;
    assign hitGr = address >= OFS_GR_BASE && idxGr < IDX_W'(NUM_GR)
        && relGr[ADDR_W-1:IDX_W+2] == '0;
    assign hitPctl = address >= OFS_PCTL_BASE
        && idxPctl < IDX_W'(NUM_GR) && relPctl[ADDR_W-1:IDX_W+2] == '0;

    logic wrRun, wrIv, wrLink, wrDstart, wrIeCnt, wrIeGr, wrIeDown;
    logic wrStCnt, wrStGr, wrStDown, wrClk, wrEdge;
    assign wrRun = wrEn && address == OFS_RUN;
    assign wrIv = wrEn && address == OFS_INTERVAL;
    assign wrLink = wrEn && address == OFS_LINK;
    assign wrDstart = wrEn && address == OFS_DSTART;
    assign wrIeCnt = wrEn && address == OFS_IE_CNT;
    assign wrIeGr = wrEn && address == OFS_IE_GR;
    assign wrIeDown = wrEn && address == OFS_IE_DOWN;
    assign wrStCnt = wrEn && address == OFS_ST_CNT;
    assign wrStGr = wrEn && address == OFS_ST_GR;
    assign wrStDown = wrEn && address == OFS_ST_DOWN;
    assign wrClk = wrEn && address == OFS_CLKSEL;
    assign wrEdge = wrEn && address == OFS_CAP0_EDGE;

    // prescaler ticks
    logic [5:0] cntMask, downMask;
    logic cntTick, downTick;
    assign cntMask = 6'((6'h01 << clkSelReg[CLK_CNT_LSB +: 3]) - 6'h01);
    assign downMask = 6'((6'h01 << clkSelReg[CLK_DOWN_LSB +: 3]) - 6'h01);
    assign cntTick = ce && (({1'b0, prescReg} & cntMask) == cntMask);
    assign downTick = ce && (({1'b0, prescReg} & downMask) == downMask);

    // per general register: match, capture, clear
    logic [NUM_GR-1:0] grMatch, grCapture, gpRise, gpFall;
    logic [NUM_CH-1:0] chClear, chOvf;
    always_comb begin
        chClear = '0;
        gpRise = gpPinIn & ~gpPrevReg;
        gpFall = ~gpPinIn & gpPrevReg;
        for (int g = 0; g < NUM_GR; g++) begin
            grMatch[g] = cntTick && runReg[GR_CHAN[g]]
                && pctlReg[g].mode == PIN_COMPARE
                && cntReg[GR_CHAN[g]][15:0] == grReg[g];
            grCapture[g] = ce && pctlReg[g].mode == PIN_CAPTURE
                && ((pctlReg[g].action[0] && gpRise[g])
                || (pctlReg[g].action[1] && gpFall[g]));
            if (GR_CHAN[g] >= FIRST_CLR_CH && pctlReg[g].clearOnMatch
                && grMatch[g]) begin
                chClear[GR_CHAN[g]] = 1'b1;
            end
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            chOvf[c] = cntTick && runReg[c] && !chClear[c]
                && (c == 0 ? cntReg[c] == CNT0_ALL_ONES
                : cntReg[c][15:0] == CNT_ALL_ONES);
        end
    end

    // channel 0 capture and interval edges
    logic [NUM_CAP0-1:0] cap0Rise, cap0Fall, cap0Hit;
    logic [NUM_IV-1:0] ivBits, ivRise;
    assign cap0Rise = ch0CaptureIn & ~cap0PrevReg;
    assign cap0Fall = ~ch0CaptureIn & cap0PrevReg;
    assign ivBits = cntReg[0][IV_BIT_LSB +: NUM_IV];
    assign ivRise = ivBits & ~ivPrevReg;
    always_comb begin
        for (int i = 0; i < NUM_CAP0; i++) begin
            cap0Hit[i] = ce && ((cap0EdgeReg[2*i] && cap0Rise[i])
                || (cap0EdgeReg[2*i+1] && cap0Fall[i]));
        end
    end

    // down-counter control
    logic [NUM_DOWN-1:0] swStart, startNow, zeroEv, underflow, downSet;
    assign swStart = wrDstart ? writedata[NUM_DOWN-1:0] & ~linkReg : '0;
    assign startNow = swStart | linkPendReg;
    assign downSet = (zeroEv & ~linkReg) | zeroDlyReg;
    always_comb begin
        for (int i = 0; i < NUM_DOWN; i++) begin
            underflow[i] = startBitReg[i] && downTick
                && dcntReg[i] == '0;
            zeroEv[i] = (startBitReg[i] && downTick && dcntReg[i] == 1)
                || (!startBitReg[i] && startNow[i] && dcntReg[i] == '0);
            startBitNext[i] = startBitReg[i];
            if (underflow[i]) begin
                startBitNext[i] = 1'b0;
            end else if (!startBitReg[i] && startNow[i]
                && dcntReg[i] != '0) begin
                startBitNext[i] = 1'b1;
            end
        end
    end

    // bus handshake: one wait state per access
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
        end else if (ce) begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    // control registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            runReg <= '0;
            intervalEnReg <= RST_BYTE;
            linkReg <= '0;
            ieCntReg <= '0;
            ieGrReg <= '0;
            ieDownReg <= '0;
            clkSelReg <= RST_BYTE;
            cap0EdgeReg <= RST_BYTE;
        end else begin
            if (wrRun) runReg <= writedata[NUM_CH-1:0];
            if (wrIv) intervalEnReg <= writedata[7:0];
            if (wrLink) linkReg <= writedata[NUM_DOWN-1:0];
            if (wrIeCnt) ieCntReg <= writedata[IE_CNT_W-1:0];
            if (wrIeGr) ieGrReg <= writedata[NUM_GR-1:0];
            if (wrIeDown) ieDownReg <= writedata[NUM_DOWN-1:0];
            if (wrClk) clkSelReg <= writedata[7:0];
            if (wrEdge) cap0EdgeReg <= writedata[7:0];
        end
    end

    // counters, captures and edge history
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prescReg <= '0;
            gpPrevReg <= '0;
            cap0PrevReg <= '0;
            ivPrevReg <= '0;
            for (int c = 0; c < NUM_CH; c++) cntReg[c] <= RST_WORD;
            for (int i = 0; i < NUM_CAP0; i++) cap0Reg[i] <= RST_WORD;
        end else if (ce) begin
            prescReg <= prescReg + 1'b1;
            gpPrevReg <= gpPinIn;
            cap0PrevReg <= ch0CaptureIn;
            ivPrevReg <= ivBits;
            for (int c = 0; c < NUM_CH; c++) begin
                if (wrEn && hitCnt && idxCnt == IDX_W'(c)) begin
                    cntReg[c] <= c == 0 ? writedata
                        : {16'h0000, writedata[15:0]};
                end else if (chClear[c]) begin
                    cntReg[c] <= RST_WORD;
                end else if (cntTick && runReg[c]) begin
                    cntReg[c] <= c == 0 ? cntReg[c] + 32'h0000_0001
                        : {16'h0000, 16'(cntReg[c][15:0] + 16'h0001)};
                end
            end
            for (int i = 0; i < NUM_CAP0; i++) begin
                if (cap0Hit[i]) cap0Reg[i] <= cntReg[0];
            end
        end
    end

    // general registers, pin control and compare pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gpPinOut <= '0;
            gpPinOe <= '0;
            for (int g = 0; g < NUM_GR; g++) begin
                grReg[g] <= '0;
                pctlReg[g] <= '0;
            end
        end else if (ce) begin
            for (int g = 0; g < NUM_GR; g++) begin
                gpPinOe[g] <= pctlReg[g].mode == PIN_COMPARE;
                if (grCapture[g]) begin
                    grReg[g] <= cntReg[GR_CHAN[g]][15:0];
                end else if (wrEn && hitGr && idxGr == IDX_W'(g)) begin
                    grReg[g] <= writedata[15:0];
                end
                if (wrEn && hitPctl && idxPctl == IDX_W'(g)) begin
                    pctlReg[g] <= ccotmr_pinctl_type'(writedata[4:0]);
                end
                if (grMatch[g]) begin
                    unique case (pctlReg[g].action)
                        ACT_LOW: gpPinOut[g] <= 1'b0;
                        ACT_HIGH: gpPinOut[g] <= 1'b1;
                        ACT_TOGGLE: gpPinOut[g] <= !gpPinOut[g];
                        default: gpPinOut[g] <= gpPinOut[g];
                    endcase
                end
            end
        end
    end

    // down-counters
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            startBitReg <= '0;
            pulseOut <= '0;
            linkPendReg <= '0;
            zeroDlyReg <= '0;
            for (int i = 0; i < NUM_DOWN; i++) dcntReg[i] <= '0;
        end else if (ce) begin
            // only underflow clears the start bit
            startBitReg <= startBitNext;
            pulseOut <= startBitNext;
            linkPendReg <= grMatch[NUM_DOWN-1:0] & linkReg;
            zeroDlyReg <= zeroEv & linkReg;
            for (int i = 0; i < NUM_DOWN; i++) begin
                if (wrEn && hitDcnt && idxDcnt == IDX_W'(i)) begin
                    dcntReg[i] <= writedata[PULSE_DOWN_COUNTER_W-1:0];
                end else if (startBitReg[i] && downTick
                    && dcntReg[i] != '0) begin
                    dcntReg[i] <= dcntReg[i] - 1'b1;
                end
            end
        end
    end

    // status flags: hardware set wins over software clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stCntReg <= '0;
            stGrReg <= '0;
            stDownReg <= '0;
        end else if (ce) begin
            stCntReg <= (stCntReg & ~(wrStCnt ? writedata[ST_CNT_W-1:0] : '0))
                | {ivRise & intervalEnReg[IV_IRQ_LSB +: NUM_IV],
                cap0Hit, chOvf};
            stGrReg <= (stGrReg & ~(wrStGr ? writedata[NUM_GR-1:0] : '0))
                | grMatch | grCapture;
            stDownReg <= (stDownReg
                & ~(wrStDown ? writedata[NUM_DOWN-1:0] : '0)) | downSet;
        end
    end

    // request lines
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ovfIrq <= '0;
            cap0Irq <= '0;
            grIrq <= '0;
            downIrq <= '0;
            intervalIrq <= 1'b0;
            adcStart <= 1'b0;
        end else if (ce) begin
            ovfIrq <= stCntReg[ST_OVF_LSB +: NUM_CH]
                & ieCntReg[ST_OVF_LSB +: NUM_CH];
            cap0Irq <= stCntReg[ST_CAP0_LSB +: NUM_CAP0]
                & ieCntReg[ST_CAP0_LSB +: NUM_CAP0];
            grIrq <= stGrReg & ieGrReg;
            downIrq <= stDownReg & ieDownReg;
            intervalIrq <= |stCntReg[ST_IV_LSB +: NUM_IV];
            adcStart <= |(ivRise & intervalEnReg[IV_ADC_LSB +: NUM_IV]);
        end
    end

    // read multiplexer
    logic [31:0] rdMux;
    always_comb begin
        rdMux = RST_WORD;
        unique case (1'b1)
            address == OFS_RUN: rdMux[NUM_CH-1:0] = runReg;
            address == OFS_INTERVAL: rdMux[7:0] = intervalEnReg;
            address == OFS_LINK: rdMux[NUM_DOWN-1:0] = linkReg;
            address == OFS_DSTART: rdMux[NUM_DOWN-1:0] = startBitReg;
            address == OFS_IE_CNT: rdMux[IE_CNT_W-1:0] = ieCntReg;
            address == OFS_IE_GR: rdMux[NUM_GR-1:0] = ieGrReg;
            address == OFS_IE_DOWN: rdMux[NUM_DOWN-1:0] = ieDownReg;
            address == OFS_ST_CNT: rdMux[ST_CNT_W-1:0] = stCntReg;
            address == OFS_ST_GR: rdMux[NUM_GR-1:0] = stGrReg;
            address == OFS_ST_DOWN: rdMux[NUM_DOWN-1:0] = stDownReg;
            address == OFS_CLKSEL: rdMux[7:0] = clkSelReg;
            address == OFS_CAP0_EDGE: rdMux[7:0] = cap0EdgeReg;
            hitCnt: rdMux = cntReg[idxCnt[2:0]];
            hitCap0: rdMux = cap0Reg[idxCap0[1:0]];
            hitDcnt: rdMux[PULSE_DOWN_COUNTER_W-1:0] = dcntReg[idxDcnt[2:0]];
            hitGr: rdMux[15:0] = grReg[idxGr[4:0]];
            hitPctl: rdMux[4:0] = pctlReg[idxPctl[4:0]];
            default: rdMux = RST_WORD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= RST_WORD;
        end else if (ce && (read || write) && waitrequest) begin
            readdata <= rdMux;
        end
    end
endmodule
`default_nettype wire

// >>> ccotmr_pkg.sv
// package: register map, field layout and types of the timer block
// Functional notes
// - on channels 1-5 a compare match drives the pin's chosen level
// - compare action per register: drive high, drive low or toggle
// - channels 3-5 only: match with clear selected zeroes the counter
// - enabled compare match raises its interrupt request
// - writing 1 to a channel's run bit starts its up-counter
// - capture edge copies the channel counter into its register
// - capture edge per input: rising, falling or both
// - enabled input capture raises its interrupt request
// - software start loads width, counts down, drives pulse pin high
// - start with down-counter at zero gives no pulse but interrupts
// - underflow clears counter and start bit, stops, drives pin low
// - start bit not clearable; writing zero ends pulse at underflow
// - zero reached interrupts; offset mode one clock later
// - link bit ties a down-counter to a channel 1 or 2 compare
// - linked compare match sets start bit and starts the pulse
// - start register writes ignored for linked down-counters
// - upper interval bits start A/D on counter 0 bit rise (10-13)
// - lower interval bits set interval flag on counter 0 bit rise
// - all four interval sources share one request line
// - counter overflow sets flag, interrupts if enabled, wraps to 0
// - stopping a counter halts only it and holds pin levels
package ccotmr_pkg;
    localparam int NUM_CH = 6;
    localparam int NUM_GR = 18;
    localparam int NUM_DOWN = 8;
    localparam int NUM_CAP0 = 4;
    localparam int NUM_IV = 4;
    localparam int ADDR_W = 9;
    localparam int IDX_W = 6;
    localparam int PRESC_W = 5;
    localparam int PULSE_DOWN_COUNTER_W_DEF = 16;
    // byte offsets
    localparam logic [8:0] OFS_RUN = 9'h000;
    localparam logic [8:0] OFS_INTERVAL = 9'h004;
    localparam logic [8:0] OFS_LINK = 9'h008;
    localparam logic [8:0] OFS_DSTART = 9'h00C;
    localparam logic [8:0] OFS_IE_CNT = 9'h010;
    localparam logic [8:0] OFS_IE_GR = 9'h014;
    localparam logic [8:0] OFS_IE_DOWN = 9'h018;
    localparam logic [8:0] OFS_ST_CNT = 9'h01C;
    localparam logic [8:0] OFS_ST_GR = 9'h020;
    localparam logic [8:0] OFS_ST_DOWN = 9'h024;
    localparam logic [8:0] OFS_CLKSEL = 9'h028;
    localparam logic [8:0] OFS_CAP0_EDGE = 9'h02C;
    localparam logic [8:0] OFS_CNT_BASE = 9'h040;
    localparam logic [8:0] OFS_CAP0_BASE = 9'h060;
    localparam logic [8:0] OFS_PULSE_DOWN_COUNTER_BASE = 9'h080;
    localparam logic [8:0] OFS_GR_BASE = 9'h100;
    localparam logic [8:0] OFS_PCTL_BASE = 9'h180;
    // field positions
    localparam int ST_OVF_LSB = 0;
    localparam int ST_CAP0_LSB = 6;
    localparam int ST_IV_LSB = 10;
    localparam int ST_CNT_W = 14;
    localparam int IE_CNT_W = 10;
    localparam int IV_IRQ_LSB = 0;
    localparam int IV_ADC_LSB = 4;
    localparam int IV_BIT_LSB = 10;
    localparam int CLK_CNT_LSB = 0;
    localparam int CLK_DOWN_LSB = 4;
    // reset values and all-ones overflow compare values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] CNT0_ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
    // owning channel of each general register
    localparam logic [2:0] GR_CHAN [NUM_GR] = '{
        3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3,
        3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5};
    localparam logic [2:0] FIRST_CLR_CH = 3'h3;
    // compare actions; capture edges share the same field
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    typedef enum logic [1:0] {
        PIN_OFF = 2'h0,
        PIN_COMPARE = 2'h1,
        PIN_CAPTURE = 2'h2,
        PIN_SPARE = 2'h3
    } ccotmr_pinmode_type;
    typedef struct packed {
        logic clearOnMatch;
        logic [1:0] action;
        ccotmr_pinmode_type mode;
    } ccotmr_pinctl_type;
endpackage

// >>> ccotmr_monitor.sv
// checker for bus handshake, pin and pulse behaviour of the timer
`timescale 1ns/1ps
`default_nettype none
module ccotmr_monitor (
    // clock, reset, bus
    input wire logic clk,
    input wire logic rst_b,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // outputs
    input wire logic [ccotmr_pkg::NUM_GR-1:0] gpPinOut,
    input wire logic [ccotmr_pkg::NUM_GR-1:0] gpPinOe,
    input wire logic [ccotmr_pkg::NUM_DOWN-1:0] pulseOut,
    input wire logic [ccotmr_pkg::NUM_DOWN-1:0] downIrq,
    input wire logic adcStart,
    input wire logic intervalIrq
);
    import ccotmr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_seen;
        (read || write) && waitrequest;
    endsequence
    sequence s_taken;
        !waitrequest ##1 waitrequest;
    endsequence
    a_bus_answer: assert property (s_seen |=> s_taken)
        else $error("bus answer not one wait");
    a_idle_wait: assert property (!(read || write) |=> waitrequest)
        else $error("waitrequest low while idle");
    a_rdata_hold: assert property (!(read || write) |=> $stable(readdata))
        else $error("readdata moved while idle");
    a_adc_single: assert property (
        adcStart |=> !adcStart [*8]) else $error("adc start repeated");
    a_pin_hold: assert property (
        ((gpPinOut ^ $past(gpPinOut)) & ~gpPinOe & ~$past(gpPinOe)) == '0)
        else $error("undriven pin changed");
    a_pulse_min: assert property (
        ($past(pulseOut) & ~pulseOut & ~$past(pulseOut, 2)) == '0)
        else $error("one cycle pulse");
    a_iv_clear: assert property (
        $fell(intervalIrq) |-> $past(write && !waitrequest, 2))
        else $error("interval request fell unasked");
    a_down_clear: assert property (
        |(~downIrq & $past(downIrq)) |-> $past(write && !waitrequest, 2))
        else $error("down request fell unasked");
endmodule
bind ccotmr_top ccotmr_monitor u_mon (.clk, .rst_b, .read, .write,
    .readdata, .waitrequest, .gpPinOut, .gpPinOe, .pulseOut, .downIrq,
    .adcStart, .intervalIrq);
`default_nettype wire

// >>> ccotmr_pin_model.sv
// far-side pin model: resolves general pins from both drivers
`timescale 1ns/1ps
`default_nettype none
module ccotmr_pin_model (
    // device and external drivers
    input wire logic [ccotmr_pkg::NUM_GR-1:0] gpPinOut,
    input wire logic [ccotmr_pkg::NUM_GR-1:0] gpPinOe,
    input wire logic [ccotmr_pkg::NUM_GR-1:0] extLevel,
    // resolved level
    output logic [ccotmr_pkg::NUM_GR-1:0] gpPinIn
);
    import ccotmr_pkg::*;
    assign gpPinIn = (gpPinOe & gpPinOut) | (~gpPinOe & extLevel);
endmodule
`default_nettype wire

// >>> ccotmr_tb_top.sv
// self-checking bench for the capture/compare one-shot timer
`timescale 1ns/1ps
`default_nettype none
module ccotmr_tb_top;
    import ccotmr_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
    logic [8:0] address = 9'h000;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata, q, x;
    logic waitrequest, adcStart, intervalIrq;
    logic [NUM_GR-1:0] gpPinIn, gpPinOut, gpPinOe, grIrq;
    logic [NUM_GR-1:0] extLevel = 18'h0_0010;
    logic [NUM_DOWN-1:0] pulseOut, downIrq;
    logic [NUM_CAP0-1:0] capIn = 4'h0, cap0Irq;
    logic [NUM_CH-1:0] ovfIrq;
    int n_fail = 0, n_compared = 0, n;
    always #12.5 clk = ~clk;
    ccotmr_top dut (.clk, .rst_b, .ce(1'b1), .address, .read, .write,
        .writedata, .readdata, .waitrequest, .ch0CaptureIn(capIn),
        .gpPinIn, .gpPinOut, .gpPinOe, .pulseOut, .adcStart, .ovfIrq,
        .cap0Irq, .grIrq, .downIrq, .intervalIrq);
    ccotmr_pin_model u_pins (.gpPinOut, .gpPinOe, .extLevel, .gpPinIn);
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bound(input int i, lim);
        if (i >= lim) begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic bus(input logic w, input logic [8:0] a, [15:0] d);
        int i;
        address <= a;
        writedata <= {16'h0000, d};
        read <= !w;
        write <= w;
        @(posedge clk);
        for (i = 0; i < 20 && waitrequest !== 1'b0; i++) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        bound(i, 20);
        @(posedge clk);
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [8:0] a, string nm, logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(nm, {16'h0000, e}, q);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(OFS_RUN, "run", 16'h0000);
        wr(9'h1FC, 16'hFFFF);
        rd(9'h1FC, "unmapped", 16'h0000);
        wr(9'h100, 16'h0005);
        wr(9'h104, 16'h0008);
        wr(9'h180, 16'h0009);
        wr(9'h184, 16'h000D);
        wr(OFS_IE_GR, 16'h0003);
        wr(OFS_RUN, 16'h0002);
        for (n = 0; n < 99 && gpPinOut[1] !== 1'b1; n++) @(posedge clk);
        chk("pins", 32'h0000_0003, {30'h0, gpPinOut[1:0]});
        chk("oe", 32'h0000_0003, {14'h0, gpPinOe});
        rd(OFS_ST_GR, "gr flags", 16'h0003);
        chk("grIrq", 32'h0000_0003, {14'h0, grIrq});
        wr(9'h100, 16'h0040);
        wr(9'h180, 16'h0005);
        for (n = 0; n < 99 && gpPinOut[0] !== 1'b0; n++) @(posedge clk);
        bound(n, 99);
        $display("test compare done");
        wr(OFS_CNT_BASE, 16'h03F0);
        wr(9'h048, 16'hFFF0);
        wr(OFS_IE_CNT, 16'h0004);
        wr(OFS_INTERVAL, 16'h0011);
        wr(9'h120, 16'h0010);
        wr(9'h1A0, 16'h0019);
        wr(OFS_RUN, 16'h000F);
        for (n = 0; n < 99 && adcStart !== 1'b1; n++) @(posedge clk);
        bound(n, 99);
        repeat (3) @(posedge clk);
        chk("ivIrq", 32'h0000_0001, {31'h0, intervalIrq});
        for (n = 0; n < 99 && ovfIrq[2] !== 1'b1; n++) @(posedge clk);
        bound(n, 99);
        rd(OFS_ST_CNT, "flags", 16'h0404);
        bus(1'b0, 9'h04C, 16'h0000);
        chk("clear", 32'h0000_0001, {31'h0, q <= 32'h0000_0010});
        wr(OFS_INTERVAL, 16'h0000);
        wr(OFS_ST_CNT, 16'h0400);
        @(posedge clk);
        chk("ivOff", 32'h0000_0000, {31'h0, intervalIrq});
        $display("test interval done");
        wr(OFS_RUN, 16'h000C);
        bus(1'b0, 9'h044, 16'h0000);
        x = q;
        wr(OFS_CNT_BASE, 16'h1234);
        wr(OFS_CAP0_EDGE, 16'h0001);
        wr(OFS_IE_CNT, 16'h0044);
        wr(9'h114, 16'h0077);
        wr(9'h18C, 16'h0006);
        wr(9'h190, 16'h000A);
        wr(9'h194, 16'h000A);
        extLevel <= 18'h0_0028;
        capIn <= 4'h1;
        repeat (4) @(posedge clk);
        rd(9'h10C, "rise", x[15:0]);
        rd(9'h110, "fall", x[15:0]);
        rd(9'h114, "none", 16'h0077);
        rd(OFS_CAP0_BASE, "cap0", 16'h1234);
        chk("cap0Irq", 32'h0000_0001, {28'h0, cap0Irq});
        $display("test capture done");
        wr(OFS_PULSE_DOWN_COUNTER_BASE, 16'h0003);
        wr(OFS_DSTART, 16'h0001);
        for (n = 0; n < 50 && pulseOut[0] === 1'b1; n++) @(posedge clk);
        chk("width", 32'h0000_0004, 32'(n));
        rd(OFS_PULSE_DOWN_COUNTER_BASE, "pulse_down_counter", 16'h0000);
        wr(OFS_IE_DOWN, 16'h0002);
        wr(9'h088, 16'h0100);
        wr(OFS_DSTART, 16'h0006);
        chk("zero", 32'h0000_0004, {24'h0, pulseOut});
        wr(OFS_DSTART, 16'h0000);
        rd(OFS_DSTART, "kept", 16'h0004);
        wr(9'h088, 16'h0000);
        for (n = 0; n < 9 && pulseOut[2] !== 1'b0; n++) @(posedge clk);
        bound(n, 9);
        chk("dIrq", 32'h0000_0001, {31'h0, downIrq[1]});
        wr(OFS_ST_DOWN, 16'h0002);
        @(posedge clk);
        chk("dOff", 32'h0000_0000, {31'h0, downIrq[1]});
        $display("test oneshot done");
        wr(OFS_RUN, 16'h0000);
        wr(9'h044, 16'h0000);
        wr(9'h100, 16'h0010);
        wr(OFS_LINK, 16'h0001);
        wr(OFS_PULSE_DOWN_COUNTER_BASE, 16'h0002);
        wr(OFS_DSTART, 16'h0001);
        rd(OFS_DSTART, "linked", 16'h0000);
        wr(OFS_RUN, 16'h0002);
        for (n = 0; n < 99 && pulseOut[0] !== 1'b1; n++) @(posedge clk);
        bound(n, 99);
        for (n = 0; n < 50 && pulseOut[0] === 1'b1; n++) @(posedge clk);
        chk("offset", 32'h0000_0003, 32'(n));
        wr(OFS_PULSE_DOWN_COUNTER_BASE, 16'h0002);
        wr(9'h044, 16'h0000);
        for (n = 0; n < 99 && pulseOut[0] !== 1'b1; n++) @(posedge clk);
        bound(n, 99);
        for (n = 0; n < 50 && pulseOut[0] === 1'b1; n++) @(posedge clk);
        chk("again", 32'h0000_0003, 32'(n));
        $display("test offset done");
        wrap_up();
    end
endmodule
`default_nettype wire
